// ==== low_power_mode_controller_test.sv ====
`timescale 1ns/100ps
module low_power_mode_controller_test;
  logic clk = 1'b0, rst_n = 1'b0, slp = 1'b0, hs = 1'b0, msk = 1'b0, bce = 1'b0;
  logic pset = 1'b0, wov = 1'b0, standby_select_bit = 1'b0, prescaler_select_bit = 1'b0, nes = 1'b0;
  logic low_speed_on_bit = 1'b0, direct_transfer_on_bit = 1'b0, ps2 = 1'b0, nev;
  logic pin_n = 1'b1, nmi = 1'b1, halt, pstop, ostop, wrun, iexc, rst_st, rexc, pirq;
  logic [15:0] ien = 16'h0000, ken = 16'h0000, irq = 16'h0000, key = 16'h0000;
  logic [15:0] wk = 16'h0000, wen = 16'h0000, hreq = 16'hFFFF, mh, men;
  logic [2:0]  mode, sts = 3'h0;
  int fails = 0, samples_checked = 0, n_irq, n_rst, n, r0, n_nmi = 0;
  always #12.5 clk = ~clk;
  always @(posedge clk) n_nmi <= n_nmi + int'(nev === 1'b1);
  lpmc_ctrl lpmc_ctrl_inst (.CLK(clk), .RST_N(rst_n), .SLEEP_EXEC(slp), .HIGH_SPEED(hs),
    .CPU_INT_MASK(msk), .BUS_CYCLE_END(bce), .PERIPH_IRQ(pirq), .PS2_IRQ(ps2),
    .WOVI_IRQ(wov), .STANDBY_SELECT_BIT(standby_select_bit), .LOW_SPEED_ON_BIT(low_speed_on_bit),
    .DIRECT_TRANSFER_ON_BIT(direct_transfer_on_bit), .PRESCALER_SELECT_BIT(prescaler_select_bit),
    .STANDBY_TIMER_SELECT_FIELD(sts), .NMI_EDGE_SELECT_BIT(nes), .IRQ_ENABLE(ien),
    .KEY_ENABLE(ken), .WAKEUP_ENABLE(wen), .MODULE_HALT_CONTROL_REG(hreq),
    .RESET_PIN_N(pin_n), .NMI_PIN(nmi), .IRQ_PINS(irq), .KEY_INPUTS(key),
    .WAKEUP_INPUTS(wk), .CPU_HALT(halt), .PERIPH_STOP(pstop), .OSC_STOP(ostop),
    .SUBCLK_WDT_RUN(wrun), .IRQ_EXCEPTION(iexc), .RESET_STATE(rst_st),
    .RESET_EXCEPTION(rexc), .NMI_EVENT(nev), .MODULE_HALT(mh), .MODULE_ACCESS_EN(men),
    .MODE(mode));
  lpmc_core_model lpmc_core_model_inst (.clk(clk), .rst_n(rst_n), .irq_exc(iexc),
    .rst_exc(rexc), .irq_set(pset), .periph_irq(pirq), .n_irq(n_irq), .n_rst(n_rst));
  task tick(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  task chk(input logic [15:0] g, input logic [15:0] e);
    samples_checked++;
    if (g !== e) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task go(input logic s, input logic p);
    @(posedge clk) {standby_select_bit, prescaler_select_bit, slp} <= {s, p, 1'b1};
    @(posedge clk) slp <= 1'b0;
    #1;
  endtask
  task wm(input logic [2:0] m);
    for (int i = 0; i < 2000 && mode !== m; i++) tick(1);
    chk(16'(mode), 16'(m));
  endtask
  task bus();
    @(posedge clk) bce <= 1'b1;
    @(posedge clk) bce <= 1'b0;
    tick(2);
  endtask
  task test_done();
    $display("checked %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (6000) @(posedge clk);
    fails++;
    test_done();
  end
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    tick(1);
    chk(mh, 16'hFFFF);
    chk(men, 16'h0000);
    go(1'b0, 1'b0);
    chk(16'({mode, halt, pstop}), 16'h0006);
    @(posedge clk) irq <= 16'h0001;
    tick(8);
    chk(16'(mode), 16'h0001);
    @(posedge clk) pset <= 1'b1;
    @(posedge clk) {pset, irq} <= 17'h0;
    wm(3'h0);
    tick(3);
    chk(16'(n_irq), 16'h0001);
    $display("sleep test done");
    @(posedge clk) {nes, msk, ien, irq, wk} <= {2'b11, 16'h0001, 16'h0001, 16'hFFFF};
    go(1'b1, 1'b0);
    chk(16'({mode, halt, pstop, ostop, wrun}), 16'h002E);
    @(posedge clk) {pset, nmi} <= 2'b10;
    @(posedge clk) pset <= 1'b0;
    tick(8);
    chk(16'(mode), 16'h0002);
    @(posedge clk) {nmi, irq, wk} <= 33'h1_0000_0000;
    wm(3'h4);
    for (n = 0; n < 2000 && mode === 3'h4; n++) tick(1);
    chk(16'(n), 16'(lpmc_pkg::LPMC_SETTLE_US0 * lpmc_pkg::LPMC_CLK_MHZ));
    tick(3);
    chk(16'(n_irq), 16'h0002);
    chk(16'(n_nmi), 16'h0001);
    $display("standby test done");
    @(posedge clk) {hs, msk, ken, key, sts} <= {2'b11, 16'h0001, 16'h0001, 3'h1};
    go(1'b1, 1'b1);
    chk(16'(mode), 16'h0003);
    tick(8);
    chk(16'(mode), 16'h0003);
    @(posedge clk) key <= 16'h0000;
    tick(3);
    @(posedge clk) {wov, msk} <= 2'b10;
    @(posedge clk) wov <= 1'b0;
    #1;
    wm(3'h4);
    for (n = 0; n < 2000 && mode === 3'h4; n++) tick(1);
    chk(16'(n), 16'(lpmc_pkg::LPMC_SETTLE_US1 * lpmc_pkg::LPMC_CLK_MHZ));
    tick(3);
    chk(16'(n_irq), 16'h0003);
    $display("watch test done");
    @(posedge clk) low_speed_on_bit <= 1'b1;
    go(1'b0, 1'b0);
    chk(16'(mode), 16'h0000);
    @(posedge clk) {low_speed_on_bit, direct_transfer_on_bit} <= 2'b01;
    go(1'b1, 1'b1);
    chk(16'(mode), 16'h0000);
    @(posedge clk) direct_transfer_on_bit <= 1'b0;
    go(1'b0, 1'b0);
    chk(16'(mode), 16'h0001);
    @(posedge clk) ps2 <= 1'b1;
    wm(3'h0);
    @(posedge clk) ps2 <= 1'b0;
    go(1'b0, 1'b0);
    chk(16'(mode), 16'h0001);
    @(posedge clk) {wen, wk} <= 32'h0001_0001;
    wm(3'h0);
    @(posedge clk) {wen, wk} <= 32'h0;
    tick(3);
    chk(16'(n_irq), 16'h0005);
    $display("mode select test done");
    r0 = n_rst;
    go(1'b0, 1'b0);
    @(posedge clk) pin_n <= 1'b0;
    tick(10);
    chk(16'({rst_st, mode}), 16'h0008);
    @(posedge clk) pin_n <= 1'b1;
    tick(6);
    chk(16'(n_rst - r0), 16'h0001);
    $display("reset pin test done");
    @(posedge clk) hreq <= 16'hFF00;
    tick(4);
    chk(mh, 16'hFFFF);
    bus();
    chk(mh, 16'hFF00);
    chk(men, 16'h00FF);
    @(posedge clk) hreq <= 16'hFFFF;
    bus();
    chk(mh, 16'hFFFF);
    $display("module halt test done");
    test_done();
  end
endmodule // low_power_mode_controller_test

// ==== lpmc_core_model.sv ====
`timescale 1ns/100ps
module lpmc_core_model (
  input  wire logic clk,
  input  wire logic rst_n,
  input  wire logic irq_exc,
  input  wire logic rst_exc,
  input  wire logic irq_set,
  output logic      periph_irq,
  output int        n_irq,
  output int        n_rst
);
  // handler entry clears the level request
  always_ff @(posedge clk) begin
    periph_irq <= rst_n & (irq_set | (periph_irq & !irq_exc));
    n_irq <= rst_n ? n_irq + int'(irq_exc) : 0;
    n_rst <= rst_n ? n_rst + int'(rst_exc) : 0;
  end
endmodule // lpmc_core_model

// ==== lpmc_ctrl.sv ====
// Contract
// RULE_01: sleep instruction, standby and low-speed off: sleep
// RULE_02: sleep halts processor, peripherals keep running
// RULE_03: accepted interrupt ends sleep; masked ones do not
// RULE_04: reset pin low enters reset state
// RULE_05: standby select, no low speed, no prescaler: standby
// RULE_06: standby stops processor, peripherals and oscillator
// RULE_07: only external, PS2 or reset end standby
// RULE_08: wake restarts oscillator, waits selected settling time
// RULE_09: disabled or masked lines never end standby
// RULE_10: software enables wake sources, blocks higher priority
// RULE_11: reset in standby restarts oscillator, clock supplied
// RULE_12: reset held low until oscillation is stable
// RULE_13: edge select chooses falling or rising nmi
// RULE_14: standby, no direct transfer, prescaler set: watch mode; code also requires HIGH_SPEED
// RULE_15: watch stops all but subclock watchdog
// RULE_16: watch ends on watchdog, external, PS2, reset
// RULE_17: watch wake settles then starts exception handling
// RULE_18: disabled or masked peripheral irqs keep watch
// RULE_19: module halt bit acts at bus cycle end
// RULE_20: all modules halted after reset
// RULE_21: halted module ignores register access
`timescale 1ns/100ps
module lpmc_ctrl import lpmc_pkg::*; #(
  parameter int NIRQ = LPMC_NUM_IRQ,
  parameter int NKEY = LPMC_NUM_KEY,
  parameter int NWK  = LPMC_NUM_WAKE,
  parameter int NMOD = LPMC_NUM_MOD
) (
  // clock and reset
  input  wire logic                  CLK,
  input  wire logic                  RST_N,
  // processor side
  input  wire logic                  SLEEP_EXEC,
  input  wire logic                  HIGH_SPEED,
  input  wire logic                  CPU_INT_MASK,
  input  wire logic                  BUS_CYCLE_END,
  input  wire logic                  PERIPH_IRQ,
  input  wire logic                  PS2_IRQ,
  input  wire logic                  WOVI_IRQ,
  // control bits
  input  wire logic                  STANDBY_SELECT_BIT,
  input  wire logic                  LOW_SPEED_ON_BIT,
  input  wire logic                  DIRECT_TRANSFER_ON_BIT,
  input  wire logic                  PRESCALER_SELECT_BIT,
  input  wire logic [LPMC_STS_W-1:0] STANDBY_TIMER_SELECT_FIELD,
  input  wire logic                  NMI_EDGE_SELECT_BIT,
  input  wire logic [NIRQ-1:0]       IRQ_ENABLE,
  input  wire logic [NKEY-1:0]       KEY_ENABLE,
  input  wire logic [NWK-1:0]        WAKEUP_ENABLE,
  input  wire logic [NMOD-1:0]       MODULE_HALT_CONTROL_REG,
  // pins
  input  wire logic                  RESET_PIN_N,
  input  wire logic                  NMI_PIN,
  input  wire logic [NIRQ-1:0]       IRQ_PINS,
  input  wire logic [NKEY-1:0]       KEY_INPUTS,
  input  wire logic [NWK-1:0]        WAKEUP_INPUTS,
  // outputs
  output logic                       CPU_HALT,
  output logic                       PERIPH_STOP,
  output logic                       OSC_STOP,
  output logic                       SUBCLK_WDT_RUN,
  output logic                       IRQ_EXCEPTION,
  output logic                       RESET_STATE,
  output logic                       RESET_EXCEPTION,
  output logic                       NMI_EVENT,
  output logic [NMOD-1:0]            MODULE_HALT,
  output logic [NMOD-1:0]            MODULE_ACCESS_EN,
  output logic [2:0]                 MODE
);
  localparam int NP = 3 + NIRQ + NKEY + NWK;

  lpmc_state_t           state_r, state_nxt;
  logic [LPMC_CNT_W-1:0] cnt_r, cnt_nxt;
  logic [NP-1:0]         pin_s;
  logic                  res_n_s, nmi_s, nmi_d_r, res_d_r;
  logic [NIRQ-1:0]       irq_s;
  logic [NKEY-1:0]       key_s;
  logic [NWK-1:0]        wk_s;
  logic [NMOD-1:0]       halt_w;
  logic                  exc_r, rstx_r, nmi_ev_r;

  lpmc_sync #(.W(NP)) u_sync (
    .clk   (CLK),
    .rst_n (RST_N),
    .d     ({RESET_PIN_N, NMI_PIN, 1'b0, IRQ_PINS, KEY_INPUTS, WAKEUP_INPUTS}),
    .q     (pin_s)
  );

  assign res_n_s = pin_s[NP-1];
  assign nmi_s   = pin_s[NP-2];
  assign irq_s   = pin_s[NKEY+NWK +: NIRQ];
  assign key_s   = pin_s[NWK +: NKEY];
  assign wk_s    = pin_s[0 +: NWK];

  // RULE_13 edge select
  wire nmi_raw  = (NMI_EDGE_SELECT_BIT == LPMC_NMI_FALL) ? (nmi_d_r & ~nmi_s)
                                                         : (~nmi_d_r & nmi_s);
  // synchroniser flops leave reset at 0, so no edge counts until they hold real pin levels
  wire nmi_edge = nmi_raw & res_d_r;
  // RULE_09 masked sources ignored
  wire irq_ok = |(irq_s & IRQ_ENABLE) & ~CPU_INT_MASK;
  wire key_ok = (|(key_s & KEY_ENABLE) | |(wk_s & WAKEUP_ENABLE)) & ~CPU_INT_MASK;
  // RULE_07 external wake set
  wire ext_wake = nmi_edge | irq_ok | key_ok | (PS2_IRQ & ~CPU_INT_MASK);
  // RULE_18 peripheral irqs masked
  wire per_ok = PERIPH_IRQ & ~CPU_INT_MASK;
  // RULE_03 any accepted interrupt
  wire any_int = ext_wake | per_ok | (WOVI_IRQ & ~CPU_INT_MASK);
  // RULE_16 watch wake set
  wire watch_wake = ext_wake | (WOVI_IRQ & ~CPU_INT_MASK);

  // RULE_01 sleep entry
  wire go_sleep = SLEEP_EXEC & ~STANDBY_SELECT_BIT & ~LOW_SPEED_ON_BIT;
  // RULE_05 standby entry
  wire go_stby  = SLEEP_EXEC & STANDBY_SELECT_BIT & ~LOW_SPEED_ON_BIT & ~PRESCALER_SELECT_BIT;
  // RULE_14 watch entry
  wire go_watch = SLEEP_EXEC & HIGH_SPEED & STANDBY_SELECT_BIT & ~DIRECT_TRANSFER_ON_BIT
                  & PRESCALER_SELECT_BIT;
  wire [LPMC_CNT_W-1:0] settle = lpmc_settle_cycles(STANDBY_TIMER_SELECT_FIELD);

  always_comb begin
    state_nxt = state_r;
    cnt_nxt   = cnt_r;
    case (state_r)
      LPMC_RUN: begin
        if (go_sleep) begin
          state_nxt = LPMC_SLEEP;
        end else if (go_stby) begin
          state_nxt = LPMC_STANDBY;
        end else if (go_watch) begin
          state_nxt = LPMC_WATCH;
        end
      end
      LPMC_SLEEP: begin
        if (any_int) begin
          state_nxt = LPMC_RUN;
        end
      end
      // RULE_08 oscillator restart wait
      LPMC_STANDBY: begin
        if (ext_wake) begin
          state_nxt = LPMC_SETTLE;
          cnt_nxt   = settle;
        end
      end
      // RULE_17 watch wake settles
      LPMC_WATCH: begin
        if (watch_wake) begin
          state_nxt = LPMC_SETTLE;
          cnt_nxt   = settle;
        end
      end
      LPMC_SETTLE: begin
        if (cnt_r <= LPMC_CNT_W'(1)) begin
          state_nxt = LPMC_RUN;
        end else begin
          cnt_nxt = cnt_r - LPMC_CNT_W'(1);
        end
      end
      default: state_nxt = LPMC_RUN;
    endcase
    // RULE_04 pin forces run
    if (!res_n_s) begin
      state_nxt = LPMC_RUN;
      cnt_nxt   = '0;
    end
  end

  wire wake_done = (state_r == LPMC_SETTLE) && (state_nxt == LPMC_RUN);
  wire sleep_done = (state_r == LPMC_SLEEP) && any_int;

  always_ff @(posedge CLK) begin
    // RULE_04 reset pin entry
    // RULE_11 reset restarts oscillator
    if (!RST_N || !res_n_s) begin
      state_r <= LPMC_RUN;
      cnt_r   <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r   <= cnt_nxt;
    end
  end

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      nmi_d_r  <= 1'b0;
      res_d_r  <= 1'b0;
      exc_r    <= 1'b0;
      rstx_r   <= 1'b0;
      nmi_ev_r <= 1'b0;
    end else begin
      nmi_d_r  <= nmi_s;
      res_d_r  <= res_n_s;
      exc_r    <= res_n_s & (sleep_done | wake_done);
      // RULE_12 exception on pin release
      rstx_r   <= res_n_s & ~res_d_r;
      nmi_ev_r <= nmi_edge;
    end
  end

  // RULE_19 halt at bus end
  // RULE_20 halted after reset
  lpmc_halt #(.N(NMOD)) u_halt (
    .clk      (CLK),
    .rst_n    (RST_N & res_n_s),
    .halt_req (MODULE_HALT_CONTROL_REG),
    .bus_end  (BUS_CYCLE_END),
    .halt_r   (halt_w)
  );

  always_ff @(posedge CLK) begin
    if (!RST_N) begin
      CPU_HALT         <= 1'b0;
      PERIPH_STOP      <= 1'b0;
      OSC_STOP         <= 1'b0;
      SUBCLK_WDT_RUN   <= 1'b1;
      IRQ_EXCEPTION    <= 1'b0;
      RESET_STATE      <= 1'b1;
      RESET_EXCEPTION  <= 1'b0;
      NMI_EVENT        <= 1'b0;
      MODULE_HALT      <= LPMC_HALT_RST[NMOD-1:0];
      MODULE_ACCESS_EN <= '0;
      MODE             <= 3'h0;
    end else begin
      // RULE_02 sleep halts processor
      CPU_HALT         <= (state_nxt != LPMC_RUN) & res_n_s;
      // RULE_06 standby stops all
      // RULE_15 watch keeps subclock watchdog
      PERIPH_STOP      <= (state_nxt == LPMC_STANDBY) | (state_nxt == LPMC_WATCH);
      OSC_STOP         <= ((state_nxt == LPMC_STANDBY) | (state_nxt == LPMC_WATCH)) & res_n_s;
      SUBCLK_WDT_RUN   <= state_nxt != LPMC_STANDBY;
      IRQ_EXCEPTION    <= exc_r;
      RESET_STATE      <= ~res_n_s;
      RESET_EXCEPTION  <= rstx_r;
      NMI_EVENT        <= nmi_ev_r;
      MODULE_HALT      <= halt_w;
      // RULE_21 halted modules ignore access
      MODULE_ACCESS_EN <= ~halt_w;
      MODE             <= state_nxt;
    end
  end
endmodule // lpmc_ctrl

// ==== lpmc_ctrl_monitor.sv ====
`timescale 1ns/100ps
module lpmc_ctrl_monitor import lpmc_pkg::*; (
  // clock and reset
  input wire logic        CLK,
  input wire logic        RST_N,
  // controls
  input wire logic        SLEEP_EXEC,
  input wire logic        HIGH_SPEED,
  input wire logic        BUS_CYCLE_END,
  input wire logic        STANDBY_SELECT_BIT,
  input wire logic        LOW_SPEED_ON_BIT,
  input wire logic        DIRECT_TRANSFER_ON_BIT,
  input wire logic        PRESCALER_SELECT_BIT,
  // status
  input wire logic [2:0]  MODE,
  input wire logic        CPU_HALT,
  input wire logic        PERIPH_STOP,
  input wire logic        OSC_STOP,
  input wire logic        SUBCLK_WDT_RUN,
  input wire logic        RESET_STATE,
  input wire logic [15:0] MODULE_HALT,
  input wire logic [15:0] MODULE_ACCESS_EN
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  logic        go;
  logic [15:0] stl_r;
  assign go = MODE == 3'h0 && SLEEP_EXEC && !RESET_STATE;
  // cycles spent in the settling state
  always_ff @(posedge CLK) begin
    stl_r <= (!RST_N || MODE != 3'h4) ? 16'h0000 : stl_r + 16'h0001;
  end
  AST_SLEEP_GO: assert property (go && !STANDBY_SELECT_BIT && !LOW_SPEED_ON_BIT
    |=> MODE == 3'h1) else $error("sleep not entered");
  AST_STBY_GO: assert property (go && STANDBY_SELECT_BIT && !LOW_SPEED_ON_BIT
    && !PRESCALER_SELECT_BIT |=> MODE == 3'h2) else $error("standby not entered");
  AST_WATCH_GO: assert property (go && HIGH_SPEED && STANDBY_SELECT_BIT
    && !LOW_SPEED_ON_BIT && !DIRECT_TRANSFER_ON_BIT && PRESCALER_SELECT_BIT
    |=> MODE == 3'h3) else $error("watch not entered");
  AST_SLEEP_HOLD: assert property (MODE == 3'h1
    |-> CPU_HALT && !PERIPH_STOP && !OSC_STOP) else $error("sleep outputs wrong");
  AST_STBY_HOLD: assert property (MODE == 3'h2
    |-> CPU_HALT && PERIPH_STOP && OSC_STOP && !SUBCLK_WDT_RUN) else $error("standby outputs");
  AST_WATCH_HOLD: assert property (MODE == 3'h3
    |-> CPU_HALT && PERIPH_STOP && SUBCLK_WDT_RUN) else $error("watch outputs wrong");
  AST_SETTLE_LEN: assert property ($past(MODE) == 3'h4 && MODE == 3'h0
    |-> stl_r >= 16'h013F) else $error("settling too short");
  AST_HALT_BUS: assert property (!$stable(MODULE_HALT) && !RESET_STATE
    |-> $past(BUS_CYCLE_END) || $past(BUS_CYCLE_END, 2)) else $error("halt off bus end");
  AST_ACCESS: assert property (MODULE_ACCESS_EN == ~MODULE_HALT)
    else $error("access not blocked");
  AST_RESET_RUN: assert property (RESET_STATE
    |-> MODE == 3'h0 && !CPU_HALT && !OSC_STOP) else $error("reset state not run");
endmodule // lpmc_ctrl_monitor

bind lpmc_ctrl lpmc_ctrl_monitor lpmc_ctrl_monitor_inst (.CLK(CLK), .RST_N(RST_N),
  .SLEEP_EXEC(SLEEP_EXEC), .HIGH_SPEED(HIGH_SPEED), .BUS_CYCLE_END(BUS_CYCLE_END),
  .STANDBY_SELECT_BIT(STANDBY_SELECT_BIT), .LOW_SPEED_ON_BIT(LOW_SPEED_ON_BIT),
  .DIRECT_TRANSFER_ON_BIT(DIRECT_TRANSFER_ON_BIT), .MODE(MODE), .CPU_HALT(CPU_HALT),
  .PRESCALER_SELECT_BIT(PRESCALER_SELECT_BIT), .PERIPH_STOP(PERIPH_STOP),
  .OSC_STOP(OSC_STOP), .SUBCLK_WDT_RUN(SUBCLK_WDT_RUN), .RESET_STATE(RESET_STATE),
  .MODULE_HALT(MODULE_HALT), .MODULE_ACCESS_EN(MODULE_ACCESS_EN));

// ==== lpmc_halt.sv ====
`timescale 1ns/100ps
module lpmc_halt import lpmc_pkg::*; #(
  parameter int N = LPMC_NUM_MOD
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // control
  input  wire logic [N-1:0] halt_req,
  input  wire logic         bus_end,
  output logic      [N-1:0] halt_r
);
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_mod
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          halt_r[i] <= LPMC_HALT_RST[i];
        end else if (bus_end) begin
          halt_r[i] <= halt_req[i];
        end
      end
    end
  endgenerate
endmodule // lpmc_halt

// ==== lpmc_pkg.sv ====
package lpmc_pkg;
  localparam int LPMC_NUM_IRQ     = 16;
  localparam int LPMC_NUM_KEY     = 16;
  localparam int LPMC_NUM_WAKE    = 16;
  localparam int LPMC_NUM_MOD     = 16;
  localparam int LPMC_STS_W       = 3;
  localparam int LPMC_CLK_MHZ     = 40;
  // settling wait per standby-timer code, in microseconds
  localparam int LPMC_SETTLE_US0  = 8;
  localparam int LPMC_SETTLE_US1  = 16;
  localparam int LPMC_SETTLE_US2  = 32;
  localparam int LPMC_SETTLE_US3  = 64;
  localparam int LPMC_SETTLE_US4  = 128;
  localparam int LPMC_SETTLE_US5  = 256;
  localparam int LPMC_SETTLE_US6  = 512;
  localparam int LPMC_SETTLE_US7  = 1024;
  localparam int LPMC_CNT_W       = 16;
  localparam logic [15:0] LPMC_HALT_RST = 16'hFFFF;
  localparam logic LPMC_NMI_FALL  = 1'b0;

  typedef enum logic [2:0] {
    LPMC_RUN, LPMC_SLEEP, LPMC_STANDBY, LPMC_WATCH, LPMC_SETTLE
  } lpmc_state_t;

  // settling wait in cycles for a standby-timer code
  function automatic logic [LPMC_CNT_W-1:0] lpmc_settle_cycles(input logic [2:0] sel);
    int us;
    case (sel)
      3'h0: us = LPMC_SETTLE_US0;
      3'h1: us = LPMC_SETTLE_US1;
      3'h2: us = LPMC_SETTLE_US2;
      3'h3: us = LPMC_SETTLE_US3;
      3'h4: us = LPMC_SETTLE_US4;
      3'h5: us = LPMC_SETTLE_US5;
      3'h6: us = LPMC_SETTLE_US6;
      default: us = LPMC_SETTLE_US7;
    endcase
    return LPMC_CNT_W'(us * LPMC_CLK_MHZ);
  endfunction
endpackage

// ==== lpmc_sync.sv ====
`timescale 1ns/100ps
module lpmc_sync import lpmc_pkg::*; #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // data
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] s1_r;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s1_r <= '0;
      q    <= '0;
    end else begin
      s1_r <= d;
      q    <= s1_r;
    end
  end
endmodule // lpmc_sync
